// [shared/scr_pkg.sv]
// constants, field layout and carrier types for the interrupt cause and
// system configuration register slots.
// assumes a 50 MHz system clock; serial frames are 16 bits, MSB first.
`default_nettype none

package scr_pkg;

   // system clock and cycle conversion
   localparam int CLK_PERIOD_NS = 20;

   // least times round up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // serial frame layout
   localparam int             CNT_W      = 5;
   localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;  // exactly sixteen clocks
   localparam logic [CNT_W-1:0] CNT_SAT   = 5'h11;  // saturates above sixteen
   localparam logic [CNT_W-1:0] CNT_SEL   = 5'h02;  // edges before select bit
   localparam int             FRAME_W    = 16;
   localparam int             PAYLOAD_W  = 12;
   localparam int             ADDR_HI    = 15;
   localparam int             ADDR_LO    = 14;
   localparam int             RRS_BIT    = 13;
   localparam int             NOWR_BIT   = 12;
   localparam logic [1:0]     SLOT_INT   = 2'h1;
   localparam logic [1:0]     SLOT_CFG   = 2'h2;
   localparam logic [3:0]     REPLY_HEAD = 4'h0;

   // interrupt cause bit positions
   localparam int IRQ_WDOG_TO   = 11;
   localparam int IRQ_OVERTEMP  = 10;
   localparam int IRQ_GND_SHIFT = 9;
   localparam int IRQ_CLK_COUNT = 8;
   localparam int IRQ_BATTERY   = 7;
   localparam int IRQ_SUPPLY    = 6;
   localparam int IRQ_CAN_FAULT = 5;
   localparam int IRQ_LIN_FAULT = 4;
   localparam int IRQ_LOC_WAKE  = 3;
   localparam int IRQ_WDOG_RST  = 2;
   localparam int IRQ_CAN_WAKE  = 1;
   localparam int IRQ_LIN_WAKE  = 0;

   // system configuration bit positions
   localparam int CFG_GND_THR  = 9;
   localparam int CFG_RST_LEN  = 8;
   localparam int CFG_V3_HI    = 7;
   localparam int CFG_V3_LO    = 6;
   localparam int CFG_V1_MON   = 4;
   localparam int CFG_WAKE_EN  = 3;
   localparam int CFG_WAKE_SMP = 2;
   localparam int CFG_INH_ON   = 1;
   localparam int CFG_INH_LVL  = 0;
   localparam logic [PAYLOAD_W-1:0] CFG_RESET = 12'h100;  // long reset length

   // timing
   localparam int INTNH_NS     = 1000;
   localparam int RST_SHORT_NS = 2000;
   localparam int RST_LONG_NS  = 20000;
   localparam int INTNH_CYC     = ns_to_cyc(INTNH_NS);
   localparam int RST_SHORT_CYC = ns_to_cyc(RST_SHORT_NS);
   localparam int RST_LONG_CYC  = ns_to_cyc(RST_LONG_NS);
   localparam int TMR_W         = 11;

   typedef enum logic [1:0] {
      V3_OFF,
      V3_ON,
      V3_CYC_SHORT,
      V3_CYC_LONG
   } scr_v3_mode_type;

   // event sources, all on the system clock
   typedef struct packed {
      logic       wdog_timeout;   // pulse
      logic       temp_warning_flag;
      logic       gnd_shift_diag;
      logic       bat_fall;       // pulse
      logic       v1_good;
      logic       v2_good;
      logic       v3_good;
      logic       can_fail;
      logic       lin_fail;
      logic       wdog_restart;   // pulse
      logic       can_wake;       // pulse
      logic       lin_wake;       // pulse
   } scr_event_type;

   // configuration fields steering the analogue side
   typedef struct packed {
      logic            gnd_threshold_sel;
      logic            reset_length_sel;
      scr_v3_mode_type v3_supply_mode;
      logic            v1_current_mon_sel;
      logic            wake_sample_sel;
   } scr_cfg_out_type;

endpackage

`default_nettype wire

// [src/scr_regs.sv]
// interrupt cause and system configuration slots behind the serial port.
// assumes serial mode 0 (sample on rising, shift on falling clock), at least
// three system clocks between chip select falling and the first serial edge.
//
// Behaviour
// - slot 01 returns cause; no_write_flag clear also writes enable payload.
// - bit 11 set on watchdog overflow interrupt in Standby.
// - bit 10 set on every change of temperature warning flag.
// - bit 9 set on every change of ground shift diagnosis flag.
// - bit 8 set when a frame has other than sixteen clocks.
// - frames with wrong clock count are discarded; only cause bit 8 changes.
// - bit 7 set on battery sense falling edge interrupt.
// - bit 6 set when any supply good flag clears.
// - bit 5 on CAN fault change, bit 4 on LIN fault change.
// - bit 3 set on negative edge of local wake input.
// - bit 2 set on watchdog restart while watchdog off.
// - bit 1 on CAN wake interrupt, bit 0 on LIN wake.
// - slot 10 returns feedback 0 or configuration; no_write_flag suppresses write.
// - bit 9 selects widened ground shift threshold.
// - bit 8 selects long reset; forced to one on restart entry.
// - short external reset pulses are stretched to programmed length.
// - bits 7:6 select V3 off, on, cyclic short, cyclic long.
// - bit 4 selects reset versus watchdog reactivation on V1 current rise.
// - bit 3 enables wake input; disabled, wake status stays frozen.
// - bit 2 selects cyclic or continuous wake sampling.
// - bit 1 enables inhibit output, bit 0 gives its level.
// - cause cleared after read and on reset; events during read kept.
// - interrupt output released for a fixed time after a cause read.
`default_nettype none

module scr_regs
   import scr_pkg::*;
(
   input  wire logic                  I_MCLK,
   input  wire logic                  I_RST_N,
   input  wire logic                  I_SCK,
   input  wire logic                  I_SCS_N,
   input  wire logic                  I_SDI,
   output logic                       O_SDO,
   output logic                       O_SDO_OE_N,
   input  wire scr_event_type         I_EVENTS,
   input  wire logic [PAYLOAD_W-1:0]  I_GP_FEEDBACK0,
   input  wire logic                  I_RESTART_ENTRY,
   input  wire logic                  I_WAKE,
   input  wire logic                  I_EXT_RST_N,
   output logic                       O_RST_N,
   output logic                       O_IRQ_N,
   output logic                       O_IE_WSTB,
   output logic [PAYLOAD_W-1:0]       O_IE_WDATA,
   output scr_cfg_out_type            O_CFG,
   output logic                       O_WAKE_EN,
   output logic                       O_WAKE_LEVEL,
   output logic                       O_INH_OUT,
   output logic                       O_INH_OE_N
);

   // serial clock domain
   logic                 fresh;
   logic [FRAME_W-1:0]   rx;
   logic [CNT_W-1:0]     cnt;
   logic [1:0]           sel_addr;
   logic                 sel_rrs;
   logic                 sdo_q;
   logic [FRAME_W-1:0]   reply;

   // system clock domain
   logic                 cs_s1, cs_s2, cs_s3;
   logic                 wake_s1, wake_s2, wake_s3;
   logic                 ext_s1, ext_s2;
   logic                 frame_end, frame_ok, int_read, cfg_write;
   logic [PAYLOAD_W-1:0] cause, next_cause, set_vec, late_set;
   logic [PAYLOAD_W-1:0] cfg;
   logic [PAYLOAD_W-1:0] snap_int, snap_cfg, snap_gp0;
   scr_event_type        ev_prev;
   logic                 primed;
   logic [TMR_W-1:0]     rel_cnt;
   logic [TMR_W-1:0]     rst_cnt, next_rst_cnt;
   logic                 rst_event;

   // frame start flag: set while chip select is high, dropped by the first edge
   always_ff @(posedge I_SCK or posedge I_SCS_N) begin
      if (I_SCS_N) begin
         fresh <= '1;
      end else begin
         fresh <= '0;
      end
   end

   // shift in on rising edge; count saturates so overlong frames stay visible
   always_ff @(posedge I_SCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx       <= '0;
         cnt      <= '0;
         sel_addr <= '0;
         sel_rrs  <= '0;
      end else begin
         if (fresh) begin
            rx  <= {{(FRAME_W-1){1'b0}}, I_SDI};
            cnt <= CNT_W'(1);
         end else begin
            rx  <= {rx[FRAME_W-2:0], I_SDI};
            cnt <= (cnt == CNT_SAT) ? CNT_SAT : cnt + CNT_W'(1);
         end
         // slot and select known once the third bit arrives
         if (!fresh && cnt == CNT_SEL) begin
            sel_addr <= rx[1:0];
            sel_rrs  <= I_SDI;
         end
      end
   end

   // reply word; snapshots are frozen while the frame runs
   always_comb begin
      reply = '0;
      if (sel_addr == SLOT_INT) begin
         reply = {REPLY_HEAD, snap_int};  // select bit ignored here
      end else if (sel_addr == SLOT_CFG) begin
         reply = {REPLY_HEAD, sel_rrs ? snap_gp0 : snap_cfg};
      end
   end

   // shift out on falling edge, bit index follows received count
   always_ff @(negedge I_SCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sdo_q <= '0;
      end else if (cnt < CNT_FRAME) begin
         sdo_q <= reply[4'(FRAME_W - 1 - int'(cnt))];
      end else begin
         sdo_q <= '0;
      end
   end

   // first bit is the zero header until the first rising edge
   assign O_SDO      = fresh ? 1'b0 : sdo_q;
   assign O_SDO_OE_N = I_SCS_N;

   // pin synchronisers; the second stage gives the level, the third stage of select and wake only feeds edge detection
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cs_s1   <= '1;
         cs_s2   <= '1;
         cs_s3   <= '1;
         wake_s1 <= '1;
         wake_s2 <= '1;
         wake_s3 <= '1;
         ext_s1  <= '1;
         ext_s2  <= '1;
      end else begin
         cs_s1   <= I_SCS_N;
         cs_s2   <= cs_s1;
         cs_s3   <= cs_s2;
         wake_s1 <= I_WAKE;
         wake_s2 <= wake_s1;
         wake_s3 <= wake_s2;
         ext_s1  <= I_EXT_RST_N;
         ext_s2  <= ext_s1;
      end
   end

   // frame end: serial clock is quiet, so rx and cnt are stable to read
   assign frame_end = cs_s2 && !cs_s3;
   assign frame_ok  = frame_end && (cnt == CNT_FRAME);
   assign int_read  = frame_ok && (rx[ADDR_HI:ADDR_LO] == SLOT_INT);
   assign cfg_write = frame_ok && (rx[ADDR_HI:ADDR_LO] == SLOT_CFG) && !rx[NOWR_BIT];

   // snapshots follow live values only between frames
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         snap_int <= '0;
         snap_cfg <= CFG_RESET;
         snap_gp0 <= '0;
      end else if (cs_s2) begin
         snap_int <= cause;
         snap_cfg <= cfg;
         snap_gp0 <= I_GP_FEEDBACK0;
      end
   end

   // enable register lives elsewhere; hand it the payload as a strobe
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_IE_WSTB  <= '0;
         O_IE_WDATA <= '0;
      end else begin
         O_IE_WSTB <= int_read && !rx[NOWR_BIT];
         if (int_read && !rx[NOWR_BIT]) begin
            O_IE_WDATA <= rx[PAYLOAD_W-1:0];
         end
      end
   end

   // configuration; restart entry overrides a same-cycle write of bit 8
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cfg <= CFG_RESET;
      end else begin
         if (cfg_write) begin
            cfg <= rx[PAYLOAD_W-1:0];  // reserved bits stored as written
         end
         if (I_RESTART_ENTRY) begin
            cfg[CFG_RST_LEN] <= '1;
         end
      end
   end

   // previous event levels; first cycle after reset only primes them
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ev_prev <= '0;
         primed  <= '0;
      end else begin
         ev_prev <= I_EVENTS;
         primed  <= '1;
      end
   end

   // event detection
   always_comb begin
      set_vec                = '0;
      set_vec[IRQ_WDOG_TO]   = I_EVENTS.wdog_timeout;
      set_vec[IRQ_OVERTEMP]  = primed && (I_EVENTS.temp_warning_flag
                                          != ev_prev.temp_warning_flag);
      set_vec[IRQ_GND_SHIFT] = primed && (I_EVENTS.gnd_shift_diag
                                          != ev_prev.gnd_shift_diag);
      set_vec[IRQ_CLK_COUNT] = frame_end && (cnt != CNT_FRAME);
      set_vec[IRQ_BATTERY]   = I_EVENTS.bat_fall;
      set_vec[IRQ_SUPPLY]    = primed && ((ev_prev.v1_good && !I_EVENTS.v1_good)
                                          || (ev_prev.v2_good && !I_EVENTS.v2_good)
                                          || (ev_prev.v3_good && !I_EVENTS.v3_good));
      set_vec[IRQ_CAN_FAULT] = primed && (I_EVENTS.can_fail != ev_prev.can_fail);
      set_vec[IRQ_LIN_FAULT] = primed && (I_EVENTS.lin_fail != ev_prev.lin_fail);
      set_vec[IRQ_LOC_WAKE]  = cfg[CFG_WAKE_EN] && wake_s3 && !wake_s2;
      set_vec[IRQ_WDOG_RST]  = I_EVENTS.wdog_restart;
      set_vec[IRQ_CAN_WAKE]  = I_EVENTS.can_wake;
      set_vec[IRQ_LIN_WAKE]  = I_EVENTS.lin_wake;
   end

   // only bits shown to the host are cleared; a set seen after the snapshot survives
   always_comb begin
      if (rst_event) begin
         next_cause = '0;
      end else begin
         next_cause = (cause & ~(int_read ? (snap_int & ~late_set) : '0)) | set_vec;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         cause    <= '0;
         late_set <= '0;
      end else begin
         cause    <= next_cause;
         late_set <= (cs_s2 ? '0 : late_set) | set_vec;  // restarts with each snapshot
      end
   end

   // interrupt line released after a read to force a fresh falling edge
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rel_cnt <= '0;
         O_IRQ_N <= '1;
      end else begin
         if (int_read) begin
            rel_cnt <= TMR_W'(INTNH_CYC);
         end else if (rel_cnt != '0) begin
            rel_cnt <= rel_cnt - TMR_W'(1);
         end
         O_IRQ_N <= int_read || (rel_cnt > TMR_W'(1)) || (next_cause == '0);
      end
   end

   // reset stretching; length sampled while the external reset is held
   always_comb begin
      if (!ext_s2) begin
         next_rst_cnt = cfg[CFG_RST_LEN] ? TMR_W'(RST_LONG_CYC)
                                         : TMR_W'(RST_SHORT_CYC);
      end else if (rst_cnt != '0) begin
         next_rst_cnt = rst_cnt - TMR_W'(1);
      end else begin
         next_rst_cnt = '0;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_cnt <= '0;
         O_RST_N <= '1;
      end else begin
         rst_cnt <= next_rst_cnt;
         O_RST_N <= (next_rst_cnt == '0);
      end
   end

   assign rst_event = !O_RST_N;

   // wake level frozen while the port is disabled
   always_ff @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_WAKE_LEVEL <= '1;
      end else if (cfg[CFG_WAKE_EN]) begin
         O_WAKE_LEVEL <= wake_s2;
      end
   end

   // configuration fields toward the analogue side
   assign O_CFG.gnd_threshold_sel  = cfg[CFG_GND_THR];
   assign O_CFG.reset_length_sel   = cfg[CFG_RST_LEN];
   assign O_CFG.v3_supply_mode     = scr_v3_mode_type'(cfg[CFG_V3_HI:CFG_V3_LO]);
   assign O_CFG.v1_current_mon_sel = cfg[CFG_V1_MON];
   assign O_CFG.wake_sample_sel    = cfg[CFG_WAKE_SMP];
   assign O_WAKE_EN                = cfg[CFG_WAKE_EN];

   // inhibit pin floats unless enabled
   assign O_INH_OE_N = !cfg[CFG_INH_ON];
   assign O_INH_OUT  = cfg[CFG_INH_ON] && cfg[CFG_INH_LVL];

   // checks
   chk_count_flag: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      frame_end && cnt != CNT_FRAME && !rst_event |=> cause[IRQ_CLK_COUNT])
      else $error("wrong clock count not flagged");

   chk_bad_discard: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      frame_end && cnt != CNT_FRAME && !I_RESTART_ENTRY |=> $stable(cfg) && !O_IE_WSTB)
      else $error("bad frame changed a register");

   chk_temp_change: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      primed && $changed(I_EVENTS.temp_warning_flag) && !rst_event
      |=> cause[IRQ_OVERTEMP])
      else $error("temperature change not flagged");

   chk_supply_drop: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      primed && $fell(I_EVENTS.v2_good) && !rst_event |=> cause[IRQ_SUPPLY])
      else $error("supply drop not flagged");

   chk_read_clear: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      int_read && set_vec == '0 |=> (cause & $past(snap_int) & ~$past(late_set)) == '0
      && ((cause & $past(late_set)) == $past(late_set) || $past(rst_event)))
      else $error("cause not cleared after read");

   chk_irq_release: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      int_read |=> O_IRQ_N [*8])
      else $error("interrupt line not released after read");

   chk_rlc_force: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      I_RESTART_ENTRY |=> cfg[CFG_RST_LEN])
      else $error("reset length not forced long");

   chk_rst_stretch: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      $rose(ext_s2) |-> !O_RST_N ##1 !O_RST_N [*8])
      else $error("external reset not stretched");

   chk_wake_frozen: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      !cfg[CFG_WAKE_EN] |=> $stable(O_WAKE_LEVEL)
      && (!cause[IRQ_LOC_WAKE] || $past(cause[IRQ_LOC_WAKE])))
      else $error("disabled wake port changed state");

   chk_inh_pin: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
      O_INH_OE_N == !cfg[CFG_INH_ON] && (O_INH_OE_N || O_INH_OUT == cfg[CFG_INH_LVL]))
      else $error("inhibit pin wrong");

endmodule

`default_nettype wire

// [verif/scr_host.sv]
// host side of the serial port: a mode 0 master that sends one frame at a
// time and hands the reply back with a short strobe.
// assumes the bench calls frame() and leaves >= 4 system clocks between frames.
`default_nettype none

module scr_host (
   input  wire logic        i_sdo,
   input  wire logic        i_sdo_oe_n,
   output logic             o_sck,
   output logic             o_scs_n,
   output logic             o_sdi,
   output logic             o_rx_stb,
   output logic [15:0]      o_rx_data
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle bus: clock low and still, select high
   initial begin
      o_sck     = 1'b0;
      o_scs_n   = 1'b1;
      o_sdi     = 1'b0;
      o_rx_stb  = 1'b0;
      o_rx_data = '0;
   end

   // one frame of nclk clocks, 32 ns period, MSB first; extra clocks send 0
   task automatic frame(input logic [15:0] tx, input int nclk);
      logic [15:0] rx;
      rx = '0;
      o_scs_n = 1'b0;
      #80;  // select lead time, well above three system clocks
      for (int i = 0; i < nclk; i++) begin
         o_sdi = (i < 16) ? tx[15-i] : 1'b0;
         #16;
         // reply taken just before the rising edge, where it has settled;
         // an undriven reply line reads as unknown and fails the compare
         rx = {rx[14:0], (i_sdo_oe_n === 1'b0) ? i_sdo : 1'bx};
         o_sck = 1'b1;
         #16 o_sck = 1'b0;
      end
      #16 o_scs_n = 1'b1;
      o_sdi = ~o_sdi;  // deselected: data line no longer meaningful
      if (nclk == 16) begin
         o_rx_data = rx;
         o_rx_stb  = 1'b1;
         #1 o_rx_stb = 1'b0;
      end
      #100;
   endtask
endmodule

`default_nettype wire

// [verif/tb_scr_regs.sv]
// self-checking bench for the interrupt cause and configuration slots.
// assumes the host model drives the serial port; link clock runs only in frames.
`default_nettype none

module tb_scr_regs
   import scr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;

   logic            mclk, rst_n, sck, scs_n, sdi, sdo, sdo_oe_n;
   logic            restart, wake, ext_rst_n, rst_out_n, irq_n, ie_wstb;
   logic            wake_en, wake_lvl, inh_out, inh_oe_n, rx_stb;
   logic [11:0]     gp, ie_wdata, cfg_m, d;
   logic [15:0]     rx_data;
   scr_event_type   ev;
   scr_cfg_out_type cfg_o;
   logic [15:0]     exp_q[$];
   logic [11:0]     ie_q[$];
   int              fails, compares, seed, n, k, stretch;

   scr_regs u_scr_regs (.I_MCLK(mclk), .I_RST_N(rst_n), .I_SCK(sck), .I_SCS_N(scs_n),
      .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE_N(sdo_oe_n), .I_EVENTS(ev),
      .I_GP_FEEDBACK0(gp), .I_RESTART_ENTRY(restart), .I_WAKE(wake),
      .I_EXT_RST_N(ext_rst_n), .O_RST_N(rst_out_n), .O_IRQ_N(irq_n), .O_IE_WSTB(ie_wstb),
      .O_IE_WDATA(ie_wdata), .O_CFG(cfg_o), .O_WAKE_EN(wake_en), .O_WAKE_LEVEL(wake_lvl),
      .O_INH_OUT(inh_out), .O_INH_OE_N(inh_oe_n));

   scr_host u_scr_host (.i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_sck(sck), .o_scs_n(scs_n),
      .o_sdi(sdi), .o_rx_stb(rx_stb), .o_rx_data(rx_data));

   always #10 mclk = ~mclk;

   task automatic test_done;
      if (fails == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // drive just after the rising edge so no race with the design's flops
   task automatic tick(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask

   // bounded wait on irq (w=0) or stretched reset (w=1); n counts cycles
   task automatic wait_for(input int w, input logic val);
      n = 0;
      while (((w == 0) ? irq_n : rst_out_n) !== val) begin
         if (n == 2000) begin
            fails++;
            $display("[ERR] %0t wait ran out", $time);
            test_done();
         end
         tick(1);
         n++;
      end
   endtask

   // whole frame; the reply is noted first, effects land a few clocks later
   task automatic xfer(input logic [15:0] tx, input int nclk, input logic [11:0] exp);
      if (nclk == 16) exp_q.push_back({REPLY_HEAD, exp});
      u_scr_host.frame(tx, nclk);
      tick(6);
   endtask

   // frame replies against the oldest note
   always @(posedge rx_stb) begin
      if (exp_q.size() == 0) begin
         fails++;
         $display("[ERR] %0t reply without note", $time);
      end else chk(rx_data, exp_q.pop_front(), "reply");
   end

   // enable-register writes against the oldest note, looked at mid-cycle
   // where the registered strobe has settled; a stray strobe fails
   always @(negedge mclk) begin
      if (ie_wstb === 1'b1) begin
         if (ie_q.size() == 0) begin
            fails++;
            $display("[ERR] %0t unexpected enable write", $time);
         end else chk({4'h0, ie_wdata}, {4'h0, ie_q.pop_front()}, "enable write");
      end
   end

   initial begin
      seed = 32'h131f;
      fails = 0;
      compares = 0;
      mclk = 1'b0;
      rst_n = 1'b0;
      ev = '0;
      ev.v1_good = 1'b1;
      ev.v2_good = 1'b1;
      ev.v3_good = 1'b1;
      gp = 12'($random(seed));
      restart = 1'b0;
      wake = 1'b1;
      ext_rst_n = 1'b1;
      cfg_m = CFG_RESET;
      repeat (5) @(posedge mclk);
      #1 rst_n = 1'b1;
      tick(4);
      chk({12'h000, irq_n, rst_out_n, inh_oe_n, wake_lvl}, 16'h000F, "idle outputs");
      // random settings with every V3 mode and inhibit combination
      for (k = 0; k < 4; k++) begin
         d = 12'($random(seed)) & 12'h3DF;  // reserved bits kept clear
         d[7:6] = 2'(k);
         d[1:0] = 2'(k);
         xfer({SLOT_CFG, 2'b00, d}, 16, cfg_m);
         cfg_m = d;
         chk({7'h00, cfg_o, wake_en, inh_oe_n, inh_out & d[1]},
             {7'h00, d[9:6], d[4], d[2], d[3], ~d[1], d[1] & d[0]}, "cfg pins");
         gp = 12'($random(seed));
         tick(1);
         xfer({SLOT_CFG, 2'b11, ~d & 12'h3DF}, 16, gp);
      end
      xfer({SLOT_CFG, 2'b00, 12'h008}, 16, cfg_m);
      cfg_m = 12'h008;
      // too few and too many clocks: discarded, flagged
      for (k = 15; k <= 17; k += 2) xfer({SLOT_CFG, 2'b00, 12'h0C3}, k, 12'h000);
      ie_q.push_back(12'h5A5);
      xfer({SLOT_INT, 2'b10, 12'h5A5}, 16, 12'h100);
      xfer({SLOT_CFG, 2'b01, 12'h000}, 16, cfg_m);
      xfer({SLOT_INT, 2'b01, 12'h000}, 16, 12'h000);
      // pulses 11,8,2,1,0; toggles temp, ground, both faults; v2 good falls
      ev = scr_event_type'(ev ^ 12'hF5F);
      wake = 1'b0;
      tick(1);
      ev = scr_event_type'(ev & ~12'h907);
      tick(INTNH_CYC);  // outlast the release window of the previous read
      chk({15'h0000, irq_n}, 16'h0000, "irq asserted");
      fork
         xfer({SLOT_INT, 2'b01, 12'h000}, 16, 12'hEFF);
         begin
            tick(12);
            ev.can_wake = 1'b1;  // arrives mid-read, after the snapshot
            tick(1);
            ev.can_wake = 1'b0;
         end
      join
      wait_for(0, 1'b0);
      chk(16'(n >= INTNH_CYC - 10 && n <= INTNH_CYC), 16'h0001, "irq release");
      xfer({SLOT_CFG, 2'b00, 12'h000}, 16, cfg_m);
      cfg_m = 12'h000;
      wake = 1'b1;
      tick(8);
      chk({15'h0000, wake_lvl}, 16'h0000, "wake frozen");
      ev.temp_warning_flag = 1'b0;
      ev.v2_good = 1'b1;  // a rising good flag is no failure
      wake = 1'b0;
      tick(6);
      xfer({SLOT_INT, 2'b01, 12'h000}, 16, 12'h402);
      // short then long stretch; a restart entry forces the long one
      for (k = 0; k < 2; k++) begin
         if (k == 1) begin
            restart = 1'b1;
            tick(1);
            restart = 1'b0;
            tick(2);
            xfer({SLOT_CFG, 2'b01, 12'h000}, 16, 12'h100);
         end
         stretch = (k == 1) ? RST_LONG_CYC : RST_SHORT_CYC;
         ev.lin_wake = 1'b1;
         tick(1);
         ev.lin_wake = 1'b0;
         ext_rst_n = 1'b0;
         tick(3);
         ext_rst_n = 1'b1;
         wait_for(1, 1'b0);
         wait_for(1, 1'b1);
         chk(16'(n >= stretch && n <= stretch + 8), 16'h0001, "reset length");
         xfer({SLOT_INT, 2'b01, 12'h000}, 16, 12'h000);
      end
      chk(16'(exp_q.size() + ie_q.size()), 16'h0000, "notes left");
      test_done();
   end
endmodule

`default_nettype wire
